// [src/sat_pkg.sv]
// Package: register map, field layout and counts for the split auto-reload timer
package sat_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses (APB, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL     = 8'h00;
    localparam logic [7:0] OFS_RELOAD_LOW  = 8'h04;
    localparam logic [7:0] OFS_RELOAD_HIGH = 8'h08;
    localparam logic [7:0] OFS_COUNT_LOW   = 8'h0c;
    localparam logic [7:0] OFS_COUNT_HIGH  = 8'h10;
    localparam logic [7:0] OFS_CLOCK_CTRL  = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // Clock control register
    localparam int CLK_LOW_MODE_BIT  = 0;
    localparam int CLK_HIGH_MODE_BIT = 1;
    localparam int CLK_CAPTURE_BIT   = 2;
    // Interrupt enable register
    localparam int IE_TIMER_BIT      = 0;
    // Interrupt status and mask registers
    localparam int IRQ_HIGH_BIT      = 0;
    localparam int IRQ_LOW_BIT       = 1;

    // Writable bits of the control register: 7,6,5,3,2,0
    localparam logic [7:0] CONTROL_WMASK = 8'hed;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_CLK  = 3'h0;
    localparam logic [1:0] RST_IRQ  = 2'h0;

    // ------------------------------------------------------------------
    // Time base counts
    // ------------------------------------------------------------------
    localparam int         SYS_DIV       = 12;
    localparam logic [3:0] SYS_DIV_LAST  = 4'(SYS_DIV - 1);
    localparam int         EXT_DIV       = 8;
    localparam logic [2:0] EXT_DIV_LAST  = 3'(EXT_DIV - 1);
    localparam logic [7:0] BYTE_MAX      = 8'hff;

    // Control register layout
    typedef struct packed {
        logic ovf_high;
        logic ovf_low;
        logic low_irq_enable;
        logic rsvd4;
        logic split_mode;
        logic run_high;
        logic rsvd1;
        logic external_clock_select;
    } sat_ctrl_t;

    // Clock control register layout
    typedef struct packed {
        logic capture_enable;
        logic high_clock_mode;
        logic low_clock_mode;
    } sat_clk_t;

endpackage

// [src/sat_timer.sv]
// Split auto-reload timer: 16-bit or dual 8-bit up counter with APB registers
//
// Functional notes
// R1 - Count is two separately accessible bytes
// R2 - Time bases: clock, clock/12, external/8
// R3 - 16-bit mode reloads both bytes on wrap
// R4 - 16-bit overflow sets high overflow flag
// R5 - Timer interrupt enable requests on overflow
// R6 - Low-byte interrupt in 16-bit mode too
// R7 - Split with capture off: two 8-bit timers
// R8 - Each split byte reloads from its own
// R9 - Run gates high byte only when split
// R10 - Per-byte clock mode selects time base
// R11 - Split mode sets each byte's flag
// R12 - Split interrupts on high, optionally low
// R13 - Flags cleared only by software writes
// R14 - Control fields, read-only bits, zero reset
// R15 - Exactly two modes chosen by one bit
// R16 - Low flag set in both modes
// R17 - Unused control bits read zero
// R18 - Single-cycle count enables per time base
// R19 - Reload replaces count on overflow cycle
`timescale 1ns/1ns
`default_nettype none

module sat_timer (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    // External clock pin
    input  wire logic        ext_clk_i,
    // Interrupt
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sat_pkg::sat_ctrl_t ctrl_r, ctrl_nxt;
    sat_pkg::sat_clk_t  clk_cfg_r, clk_cfg_nxt;
    logic [7:0]  reload_low_r, reload_low_nxt;
    logic [7:0]  reload_high_r, reload_high_nxt;
    logic [7:0]  count_low_r, count_low_nxt;
    logic [7:0]  count_high_r, count_high_nxt;
    logic        timer_ie_r, timer_ie_nxt;
    logic [1:0]  irq_stat_r, irq_stat_nxt;
    logic [1:0]  irq_mask_r, irq_mask_nxt;
    logic [3:0]  div12_r, div12_nxt;
    logic [2:0]  div8_r, div8_nxt;
    logic        ext_meta_r, ext_sync_r, ext_prev_r;
    logic        irq_r, irq_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        slverr_r, slverr_nxt;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic wr_en;
    logic setup;
    logic tick_div12;
    logic tick_ext;
    logic tick_low;
    logic tick_high;
    logic inc_low;
    logic inc_high;
    logic ovf_low;
    logic ovf_high;
    logic split_active;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == sat_pkg::OFS_CONTROL)     || (a == sat_pkg::OFS_RELOAD_LOW) ||
                   (a == sat_pkg::OFS_RELOAD_HIGH) || (a == sat_pkg::OFS_COUNT_LOW)  ||
                   (a == sat_pkg::OFS_COUNT_HIGH)  || (a == sat_pkg::OFS_CLOCK_CTRL) ||
                   (a == sat_pkg::OFS_IRQ_ENABLE)  || (a == sat_pkg::OFS_IRQ_STATUS) ||
                   (a == sat_pkg::OFS_IRQ_MASK);
    endfunction

    // Clock mode bit 1 picks the core clock, else the prescaled source
    function automatic logic pick_tick(input logic mode, input logic xsel,
                                       input logic t12, input logic t8);
        pick_tick = mode ? 1'b1 : (xsel ? t8 : t12); // R10
    endfunction

    // A byte at its top value wraps on its next step
    function automatic logic at_top(input logic [7:0] v);
        at_top = (v == sat_pkg::BYTE_MAX);
    endfunction

    function automatic logic [7:0] bump(input logic [7:0] v);
        bump = v + 8'h01;
    endfunction

    assign setup    = psel_i && !penable_i;
    assign wr_en    = psel_i && penable_i && pwrite_i && addr_hit(paddr_i);
    assign pready_o = psel_i && penable_i;
    assign prdata_o = prdata_r;
    assign pslverr_o = slverr_r && psel_i && penable_i;

    // ------------------------------------------------------------------
    // Time bases
    // ------------------------------------------------------------------
    // Pin edges are counted only after two sync stages; the third stage
    // just remembers the last settled level for edge detection.
    assign tick_div12 = (div12_r == sat_pkg::SYS_DIV_LAST); // R2 R18
    assign tick_ext   = ext_sync_r && !ext_prev_r && (div8_r == sat_pkg::EXT_DIV_LAST); // R2 R18

    always_comb begin
        div12_nxt = tick_div12 ? 4'h0 : div12_r + 4'h1;
        div8_nxt  = div8_r;
        if (ext_sync_r && !ext_prev_r) begin
            div8_nxt = div8_r + 3'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            div12_r    <= 4'h0;
            div8_r     <= 3'h0;
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            div12_r    <= div12_nxt;
            div8_r     <= div8_nxt;
            ext_meta_r <= ext_clk_i;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
        end
    end

    // ------------------------------------------------------------------
    // Counter control
    // ------------------------------------------------------------------
    // 16-bit mode runs on the low byte's clock mode bit. Split mode with
    // capture enabled is not an auto-reload mode, so the counter holds.
    assign tick_low  = pick_tick(clk_cfg_r.low_clock_mode, ctrl_r.external_clock_select,
                                 tick_div12, tick_ext);
    assign tick_high = pick_tick(clk_cfg_r.high_clock_mode, ctrl_r.external_clock_select,
                                 tick_div12, tick_ext);
    assign split_active = ctrl_r.split_mode && !clk_cfg_r.capture_enable; // R7 R15

    always_comb begin
        if (!ctrl_r.split_mode) begin
            inc_low  = ctrl_r.run_high && tick_low;                          // R3
            inc_high = inc_low && at_top(count_low_r);                        // R3
        end else begin
            inc_low  = split_active && tick_low;                              // R9
            inc_high = split_active && ctrl_r.run_high && tick_high;          // R9
        end
        ovf_low  = inc_low && at_top(count_low_r);                            // R16
        ovf_high = inc_high && at_top(count_high_r);                          // R4 R11
    end

    // ------------------------------------------------------------------
    // Register next state
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_nxt        = ctrl_r;
        clk_cfg_nxt     = clk_cfg_r;
        reload_low_nxt  = reload_low_r;
        reload_high_nxt = reload_high_r;
        count_low_nxt   = count_low_r;
        count_high_nxt  = count_high_r;
        timer_ie_nxt    = timer_ie_r;
        irq_stat_nxt    = irq_stat_r;
        irq_mask_nxt    = irq_mask_r;

        // Counting; a wrap loads the reload in the same cycle
        if (inc_low) begin
            count_low_nxt = bump(count_low_r);
        end
        if (inc_high) begin
            count_high_nxt = bump(count_high_r);
        end
        if (!ctrl_r.split_mode) begin
            if (ovf_high) begin
                count_low_nxt  = reload_low_r;  // R3 R19
                count_high_nxt = reload_high_r; // R3 R19
            end
        end else begin
            if (ovf_low) begin
                count_low_nxt = reload_low_r;   // R8 R19
            end
            if (ovf_high) begin
                count_high_nxt = reload_high_r; // R8 R19
            end
        end

        // Software writes; a count byte write overrides counting
        if (wr_en) begin
            unique case (paddr_i)
                sat_pkg::OFS_CONTROL: begin
                    ctrl_nxt = sat_pkg::sat_ctrl_t'(pwdata_i[7:0] & sat_pkg::CONTROL_WMASK); // R14 R17
                end
                sat_pkg::OFS_RELOAD_LOW: begin
                    reload_low_nxt = pwdata_i[7:0];
                end
                sat_pkg::OFS_RELOAD_HIGH: begin
                    reload_high_nxt = pwdata_i[7:0];
                end
                sat_pkg::OFS_COUNT_LOW: begin
                    count_low_nxt = pwdata_i[7:0];  // R1
                end
                sat_pkg::OFS_COUNT_HIGH: begin
                    count_high_nxt = pwdata_i[7:0]; // R1
                end
                sat_pkg::OFS_CLOCK_CTRL: begin
                    clk_cfg_nxt = sat_pkg::sat_clk_t'(pwdata_i[2:0]);
                end
                sat_pkg::OFS_IRQ_ENABLE: begin
                    timer_ie_nxt = pwdata_i[sat_pkg::IE_TIMER_BIT];
                end
                sat_pkg::OFS_IRQ_STATUS: begin
                    irq_stat_nxt = irq_stat_r & ~pwdata_i[1:0];
                end
                sat_pkg::OFS_IRQ_MASK: begin
                    irq_mask_nxt = pwdata_i[1:0];
                end
                default: begin
                end
            endcase
        end

        // Hardware only ever sets flags, and a set beats a same-cycle clear
        if (ovf_high) begin
            ctrl_nxt.ovf_high                     = 1'b1; // R4 R11 R13
            irq_stat_nxt[sat_pkg::IRQ_HIGH_BIT]   = 1'b1;
        end
        if (ovf_low) begin
            ctrl_nxt.ovf_low                      = 1'b1; // R16 R11 R13
            irq_stat_nxt[sat_pkg::IRQ_LOW_BIT]    = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ctrl_r        <= sat_pkg::sat_ctrl_t'(sat_pkg::RST_BYTE); // R14
            clk_cfg_r     <= sat_pkg::sat_clk_t'(sat_pkg::RST_CLK);
            reload_low_r  <= sat_pkg::RST_BYTE;
            reload_high_r <= sat_pkg::RST_BYTE;
            count_low_r   <= sat_pkg::RST_BYTE;
            count_high_r  <= sat_pkg::RST_BYTE;
            timer_ie_r    <= 1'b0;
            irq_stat_r    <= sat_pkg::RST_IRQ;
            irq_mask_r    <= sat_pkg::RST_IRQ;
        end else begin
            ctrl_r        <= ctrl_nxt;
            clk_cfg_r     <= clk_cfg_nxt;
            reload_low_r  <= reload_low_nxt;
            reload_high_r <= reload_high_nxt;
            count_low_r   <= count_low_nxt;
            count_high_r  <= count_high_nxt;
            timer_ie_r    <= timer_ie_nxt;
            irq_stat_r    <= irq_stat_nxt;
            irq_mask_r    <= irq_mask_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------
    // High overflow counts when the timer interrupt and its mask bit are on; the low
    // byte also needs its mask bit and its own enable, so software must check both flags.
    // Worked out from the next state so the registered level moves at the
    // same edge as the flag or the write behind it, with no extra cycle.
    always_comb begin
        irq_nxt = timer_ie_nxt &&
                  ((irq_stat_nxt[sat_pkg::IRQ_HIGH_BIT] &&
                    irq_mask_nxt[sat_pkg::IRQ_HIGH_BIT]) ||            // R5 R12
                   (irq_stat_nxt[sat_pkg::IRQ_LOW_BIT] &&
                    irq_mask_nxt[sat_pkg::IRQ_LOW_BIT] &&
                    ctrl_nxt.low_irq_enable));                         // R6 R12
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign irq_o = irq_r;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_comb begin
        prdata_nxt = prdata_r;
        slverr_nxt = slverr_r;
        if (setup) begin
            prdata_nxt = 32'h0000_0000;
            slverr_nxt = !addr_hit(paddr_i);
            unique case (paddr_i)
                sat_pkg::OFS_CONTROL: begin
                    prdata_nxt[7:0] = ctrl_r; // R14 R17
                end
                sat_pkg::OFS_RELOAD_LOW: begin
                    prdata_nxt[7:0] = reload_low_r;
                end
                sat_pkg::OFS_RELOAD_HIGH: begin
                    prdata_nxt[7:0] = reload_high_r;
                end
                sat_pkg::OFS_COUNT_LOW: begin
                    prdata_nxt[7:0] = count_low_r;  // R1
                end
                sat_pkg::OFS_COUNT_HIGH: begin
                    prdata_nxt[7:0] = count_high_r; // R1
                end
                sat_pkg::OFS_CLOCK_CTRL: begin
                    prdata_nxt[2:0] = clk_cfg_r;
                end
                sat_pkg::OFS_IRQ_ENABLE: begin
                    prdata_nxt[sat_pkg::IE_TIMER_BIT] = timer_ie_r;
                end
                sat_pkg::OFS_IRQ_STATUS: begin
                    prdata_nxt[1:0] = irq_stat_r;
                end
                sat_pkg::OFS_IRQ_MASK: begin
                    prdata_nxt[1:0] = irq_mask_r;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            prdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            slverr_r <= slverr_nxt;
        end
    end

endmodule // sat_timer

`default_nettype wire

// [test/sat_timer_assertions.sv]
// Checker: port-level properties of the split auto-reload timer
`timescale 1ns/1ns
`default_nettype none

module sat_timer_assertions (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        srst_i,
    // APB slave
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic        pslverr_o,
    // Pins
    input wire logic        ext_clk_i,
    input wire logic        irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    // ------------------------------------------------------------------
    // Shadows of the enables, taken from completed writes
    // ------------------------------------------------------------------
    logic       ie_sh_r;
    logic [1:0] mask_sh_r;
    logic       lie_sh_r;
    logic       acc;
    assign acc = psel_i && penable_i;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ie_sh_r   <= 1'b0;
            mask_sh_r <= 2'h0;
            lie_sh_r  <= 1'b0;
        end else if (acc && pwrite_i) begin
            if (paddr_i == sat_pkg::OFS_IRQ_ENABLE) ie_sh_r <= pwdata_i[0];
            if (paddr_i == sat_pkg::OFS_IRQ_MASK) mask_sh_r <= pwdata_i[1:0];
            if (paddr_i == sat_pkg::OFS_CONTROL) lie_sh_r <= pwdata_i[5];
        end
    end

    property p_ready_in_access;
        psel_i && !penable_i ##1 acc |-> pready_o;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access)
        else $error("no ready in first access cycle");

    property p_ctrl_unused_zero;
        acc && !pwrite_i && paddr_i == sat_pkg::OFS_CONTROL |-> prdata_o[4] == 1'b0 && prdata_o[1] == 1'b0;
    endproperty
    a_ctrl_unused_zero: assert property (p_ctrl_unused_zero)
        else $error("unused control bit reads one");

    property p_byte_wide;
        acc && !pwrite_i |-> prdata_o[31:8] == 24'h0;
    endproperty
    a_byte_wide: assert property (p_byte_wide)
        else $error("read data above the byte");

    property p_unmapped_err;
        acc && paddr_i > sat_pkg::OFS_IRQ_MASK |-> pslverr_o && prdata_o == 32'h0;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access not refused");

    property p_mapped_ok;
        acc && paddr_i == sat_pkg::OFS_COUNT_LOW |-> !pslverr_o;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok)
        else $error("count byte access refused");

    property p_irq_needs_enable;
        irq_o |-> ie_sh_r && mask_sh_r != 2'h0;
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable)
        else $error("interrupt while disabled");

    property p_irq_low_gated;
        irq_o && mask_sh_r == 2'h2 |-> lie_sh_r;
    endproperty
    a_irq_low_gated: assert property (p_irq_low_gated)
        else $error("low interrupt without its enable");

    property p_irq_falls_by_write;
        $fell(irq_o) && !$past(srst_i) |-> $past(acc && pwrite_i);
    endproperty
    a_irq_falls_by_write: assert property (p_irq_falls_by_write)
        else $error("interrupt dropped without a write");
endmodule // sat_timer_assertions

bind sat_timer sat_timer_assertions u_chk (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .ext_clk_i(ext_clk_i), .irq_o(irq_o)
);

`default_nettype wire

// [test/tb_top.sv]
// Testbench: register-level checks of the split auto-reload timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module tb_top;
    logic        core_clk_i = 1'b0;
    logic        srst_i     = 1'b1;
    logic        psel_i     = 1'b0;
    logic        penable_i  = 1'b0;
    logic        pwrite_i   = 1'b0;
    logic [7:0]  paddr_i    = 8'h00;
    logic [31:0] pwdata_i   = 32'h0;
    logic        ext_clk_i  = 1'b0;
    logic        pready_o;
    logic [31:0] prdata_o;
    logic        pslverr_o;
    logic        irq_o;
    logic [31:0] rd_q;
    logic        err_q;
    logic [1:0]  ext_q      = 2'h0;
    int          fail_count   = 0;
    int          total_checks = 0;

    always #5 core_clk_i = ~core_clk_i;

    // External pin: one rising edge every 4 core cycles
    always @(posedge core_clk_i) begin
        ext_q     <= ext_q + 2'h1;
        ext_clk_i <= ext_q[1];
    end

    sat_timer u_dut (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .prdata_o(prdata_o), .pslverr_o(pslverr_o), .ext_clk_i(ext_clk_i), .irq_o(irq_o)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------------
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge core_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        paddr_i   <= a;
        pwrite_i  <= w;
        pwdata_i  <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            fail_count++;
            report_and_stop();
        end
        rd_q = prdata_o;
        err_q = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        `CHK(rd_q, e)
    endtask

    task automatic irq_is(input logic e);
        @(negedge core_clk_i);
        `CHK(irq_o, e)
    endtask

    // Counts one time base over a run window; the edges of the window may cost a tick
    task automatic rate(input logic [7:0] clk_ctl, input logic xs, input int w, input int d);
        logic [7:0] e;
        wr(sat_pkg::OFS_CONTROL, {7'h0, xs});
        wr(sat_pkg::OFS_COUNT_LOW, 8'h00);
        wr(sat_pkg::OFS_COUNT_HIGH, 8'h00);
        wr(sat_pkg::OFS_CLOCK_CTRL, clk_ctl);
        wr(sat_pkg::OFS_CONTROL, {5'h0, 1'b1, 1'b0, xs});
        repeat (w) @(posedge core_clk_i);
        wr(sat_pkg::OFS_CONTROL, {7'h0, xs});
        xfer(sat_pkg::OFS_COUNT_LOW, 1'b0, 32'h0);
        e = 8'((w + 3) / d);
        `CHK(rd_q[7:0] + 8'h2 >= e && rd_q[7:0] <= e + 8'h2, 1'b1)
    endtask

    initial begin
        repeat (100000) @(posedge core_clk_i);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge core_clk_i);
        srst_i <= 1'b0;
        for (int i = 0; i <= 8; i++) rd(8'(4 * i), 32'h0);
        xfer(8'h24, 1'b0, 32'h0);
        `CHK({err_q, rd_q}, 33'h1_0000_0000)
        wr(sat_pkg::OFS_CONTROL, 8'hff);
        rd(sat_pkg::OFS_CONTROL, 32'hed);
        rate(8'h01, 1'b0, 100, 1);
        rate(8'h00, 1'b0, 238, 12);
        rate(8'h00, 1'b1, 638, 32);
        // 16-bit wrap from ffff into the reload value
        wr(sat_pkg::OFS_RELOAD_LOW, 8'h34);
        wr(sat_pkg::OFS_RELOAD_HIGH, 8'h12);
        wr(sat_pkg::OFS_COUNT_LOW, 8'hfe);
        wr(sat_pkg::OFS_COUNT_HIGH, 8'hff);
        wr(sat_pkg::OFS_CLOCK_CTRL, 8'h01);
        wr(sat_pkg::OFS_CONTROL, 8'h04);
        repeat (20) @(posedge core_clk_i);
        rd(sat_pkg::OFS_CONTROL, 32'hc4);
        rd(sat_pkg::OFS_COUNT_HIGH, 32'h12);
        rd(sat_pkg::OFS_IRQ_STATUS, 32'h3);
        irq_is(1'b0);
        wr(sat_pkg::OFS_CONTROL, 8'h00);
        rd(sat_pkg::OFS_CONTROL, 32'h0);
        wr(sat_pkg::OFS_IRQ_MASK, 8'h01);
        wr(sat_pkg::OFS_IRQ_ENABLE, 8'h01);
        irq_is(1'b1);
        wr(sat_pkg::OFS_IRQ_MASK, 8'h02);
        irq_is(1'b0);
        wr(sat_pkg::OFS_CONTROL, 8'h20);
        irq_is(1'b1);
        wr(sat_pkg::OFS_IRQ_STATUS, 8'h02);
        irq_is(1'b0);
        repeat (50) @(posedge core_clk_i);
        rd(sat_pkg::OFS_IRQ_STATUS, 32'h1);
        // Split mode: low byte free-running, high byte held until run is set
        wr(sat_pkg::OFS_IRQ_STATUS, 8'h03);
        wr(sat_pkg::OFS_RELOAD_LOW, 8'hf0);
        wr(sat_pkg::OFS_RELOAD_HIGH, 8'he0);
        wr(sat_pkg::OFS_COUNT_HIGH, 8'h55);
        wr(sat_pkg::OFS_CLOCK_CTRL, 8'h03);
        wr(sat_pkg::OFS_CONTROL, 8'h08);
        repeat (300) @(posedge core_clk_i);
        rd(sat_pkg::OFS_COUNT_HIGH, 32'h55);
        rd(sat_pkg::OFS_CONTROL, 32'h48);
        rd(sat_pkg::OFS_IRQ_STATUS, 32'h2);
        xfer(sat_pkg::OFS_COUNT_LOW, 1'b0, 32'h0);
        `CHK(rd_q[7:4], 4'hf)
        wr(sat_pkg::OFS_CONTROL, 8'h0c);
        repeat (300) @(posedge core_clk_i);
        // High byte reloads to e0, so it can only sit within e0..ff
        xfer(sat_pkg::OFS_COUNT_HIGH, 1'b0, 32'h0);
        `CHK(rd_q[7:5], 3'h7)
        rd(sat_pkg::OFS_CONTROL, 32'hcc);
        irq_is(1'b0);
        wr(sat_pkg::OFS_CONTROL, 8'h2c);
        irq_is(1'b1);
        // Split with capture enabled is not auto-reload: the bytes hold
        wr(sat_pkg::OFS_CLOCK_CTRL, 8'h07);
        wr(sat_pkg::OFS_COUNT_LOW, 8'h11);
        repeat (40) @(posedge core_clk_i);
        rd(sat_pkg::OFS_COUNT_LOW, 32'h11);
        wr(sat_pkg::OFS_CONTROL, 8'h00);
        report_and_stop();
    end
endmodule // tb_top

`default_nettype wire
